// ==== hw/por_seq_params.svh ====
// Operation
// RULE1: Supervisor holds power-on reset sixteen input clocks.
// RULE2: Stretch internal power-on reset 1024 input clocks.
// RULE3: PLL locks after 6400 divided reference cycles.
// RULE4: Release hard reset 512 reference clocks after lock.
// RULE5: Release soft reset 515 reference clocks after lock.
// RULE6: Board keeps straps stable around power-on release.
// RULE7: Capture fourteen straps when power-on reset releases.
// RULE8: Power-on resets PLL; hard reset implies soft.
// RULE9: Down-counter delays; reassertion restarts whole sequence.
`ifndef POR_SEQ_PARAMS_SVH
`define POR_SEQ_PARAMS_SVH

`define SEQ_CTRL_OFFSET 12'h000
`define SEQ_STATUS_OFFSET 12'h004
`define SEQ_STRAPS_OFFSET 12'h008

`define CTRL_RDF_BIT 0
`define CTRL_RDF_RESET 1'b0

`define STATUS_STATE_LSB 0
`define STATUS_PLL_BIT 3
`define STATUS_HARD_PIN_BIT 4
`define STATUS_SOFT_PIN_BIT 5
`define STATUS_POR_PIN_BIT 6
`define STATUS_REMAIN_LSB 16

`define STRAP_COUNT 14
`define STRAP_RESET 14'h0000
`define STRAP_CFG_MODE 0
`define STRAP_CFG_SLAVE 1
`define STRAP_PORT_SYNC 2
`define STRAP_PORT_WIDE 3
`define STRAP_POSITION_LSB 4
`define STRAP_BOOT_LSB 8
`define STRAP_WATCHDOG 11
`define STRAP_CLKMODE_LSB 12

`define POR_MIN_CYCLES 16
`define STRETCH_CYCLES 1024
`define PLL_LOCK_CYCLES 6400
`define HARD_RELEASE_CYCLES 512
`define SOFT_RELEASE_CYCLES 515

`endif

// ==== hw/por_seq_pkg.sv ====
package por_seq_pkg;

  typedef enum logic [2:0] {
    ST_POR,
    ST_STRETCH,
    ST_PLL_WAIT,
    ST_HARD_HOLD,
    ST_SOFT_HOLD,
    ST_RUN
  } seq_state_t;

endpackage : por_seq_pkg

// ==== hw/delay_down_counter.sv ====
`timescale 1ns/1ps
module delay_down_counter #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic tick,
  output logic expire,
  output logic [WIDTH-1:0] remaining
);

  logic [WIDTH-1:0] count_q;

  initial begin
    if (WIDTH < 2) $error("delay_down_counter: WIDTH too small");
  end

  // A zero load never expires, which parks the counter in idle states.
  assign expire = tick && (count_q == WIDTH'(1));
  assign remaining = count_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= load_value;
    end else if (tick && count_q != '0) begin
      count_q <= count_q - WIDTH'(1);
    end
  end

endmodule : delay_down_counter

// ==== hw/power_on_reset_sequencer.sv ====
`timescale 1ns/1ps
`include "por_seq_params.svh"
module power_on_reset_sequencer #(
  parameter int unsigned COUNT_WIDTH = 16,
  parameter int unsigned STRETCH_CYCLES = `STRETCH_CYCLES,
  parameter int unsigned PLL_LOCK_CYCLES = `PLL_LOCK_CYCLES,
  parameter int unsigned HARD_RELEASE_CYCLES = `HARD_RELEASE_CYCLES,
  parameter int unsigned SOFT_RELEASE_CYCLES = `SOFT_RELEASE_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic input_clock,
  input wire logic reference_clock,
  input wire logic power_on_reset_n,
  input wire logic hard_reset_n_i,
  output logic hard_reset_n_o,
  output logic hard_reset_n_oe,
  input wire logic soft_reset_n_i,
  output logic soft_reset_n_o,
  output logic soft_reset_n_oe,
  input wire logic config_mode_strap,
  input wire logic config_slave_strap,
  input wire logic slave_port_sync_strap,
  input wire logic slave_port_wide_strap,
  input wire logic [3:0] device_position_code,
  input wire logic [2:0] boot_mode_strap,
  input wire logic watchdog_enable_strap,
  input wire logic [1:0] clock_mode_strap,
  output logic internal_por_n,
  output logic system_pll_reset,
  output logic system_pll_locked,
  output logic cfg_config_mode,
  output logic cfg_config_slave,
  output logic cfg_slave_port_sync,
  output logic cfg_slave_port_wide,
  output logic [3:0] cfg_device_position,
  output logic [2:0] cfg_boot_mode,
  output logic cfg_watchdog_enable,
  output logic [1:0] cfg_clock_mode,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import por_seq_pkg::*;

  localparam int unsigned NS = `STRAP_COUNT;
  localparam int unsigned SYNC_W = 5 + NS;
  localparam logic [COUNT_WIDTH-1:0] STRETCH_LOAD =
    COUNT_WIDTH'(STRETCH_CYCLES);
  localparam logic [COUNT_WIDTH-1:0] PLL_LOAD_1 =
    COUNT_WIDTH'(PLL_LOCK_CYCLES);
  localparam logic [COUNT_WIDTH-1:0] PLL_LOAD_2 =
    COUNT_WIDTH'(2 * PLL_LOCK_CYCLES);
  localparam logic [COUNT_WIDTH-1:0] HARD_LOAD =
    COUNT_WIDTH'(HARD_RELEASE_CYCLES);
  localparam logic [COUNT_WIDTH-1:0] SOFT_LOAD =
    COUNT_WIDTH'(SOFT_RELEASE_CYCLES - HARD_RELEASE_CYCLES);

  initial begin
    if (COUNT_WIDTH > 16) $error("COUNT_WIDTH must fit the status word");
    if (2 * PLL_LOCK_CYCLES >= (1 << COUNT_WIDTH))
      $error("PLL lock count does not fit the counter");
    if (STRETCH_CYCLES == 0 || HARD_RELEASE_CYCLES == 0)
      $error("delay counts must be non-zero");
    if (SOFT_RELEASE_CYCLES <= HARD_RELEASE_CYCLES)
      $error("soft release must follow hard release");
  end

  // Pin synchroniser. The sampled clocks must stay below half of clk.
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  logic [NS-1:0] strap_raw;
  logic [NS-1:0] strap_sync;
  logic in_clk_sync, ref_clk_sync, por_sync;
  logic hard_pin_sync, soft_pin_sync;
  logic in_clk_prev_q, ref_clk_prev_q, por_prev_q;
  logic in_tick, ref_tick, por_rise;

  assign strap_raw = {clock_mode_strap, watchdog_enable_strap,
                      boot_mode_strap, device_position_code,
                      slave_port_wide_strap, slave_port_sync_strap,
                      config_slave_strap, config_mode_strap};
  assign pin_raw = {strap_raw, soft_reset_n_i, hard_reset_n_i,
                    power_on_reset_n, reference_clock, input_clock};

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
    end
  end

  assign in_clk_sync = sync_q[0];
  assign ref_clk_sync = sync_q[1];
  assign por_sync = sync_q[2];
  assign hard_pin_sync = sync_q[3];
  assign soft_pin_sync = sync_q[4];
  assign strap_sync = sync_q[SYNC_W-1:5];

  always_ff @(posedge clk) begin
    if (srst) begin
      in_clk_prev_q <= 1'b0;
      ref_clk_prev_q <= 1'b0;
      por_prev_q <= 1'b0;
    end else begin
      in_clk_prev_q <= in_clk_sync;
      ref_clk_prev_q <= ref_clk_sync;
      por_prev_q <= por_sync;
    end
  end

  assign in_tick = in_clk_sync && !in_clk_prev_q;
  assign ref_tick = ref_clk_sync && !ref_clk_prev_q;
  assign por_rise = por_sync && !por_prev_q;

  // Control register: selects the PLL reference divide factor.
  logic rdf_two_q;
  logic [COUNT_WIDTH-1:0] remaining;
  seq_state_t state_q, state_d;
  logic cnt_tick, cnt_load, cnt_expire;
  logic [COUNT_WIDTH-1:0] cnt_value;

  assign cnt_tick = (state_q == ST_STRETCH || state_q == ST_PLL_WAIT)
                    ? in_tick : ref_tick;
  assign cnt_load = (state_d != state_q);

  always_comb begin
    state_d = state_q;
    // RULE9: restart on reassertion
    if (!por_sync) begin
      state_d = ST_POR;
    end else begin
      unique case (state_q)
        ST_POR: state_d = ST_STRETCH;
        ST_STRETCH: if (cnt_expire) state_d = ST_PLL_WAIT;
        ST_PLL_WAIT: if (cnt_expire) state_d = ST_HARD_HOLD;
        ST_HARD_HOLD: if (cnt_expire) state_d = ST_SOFT_HOLD;
        ST_SOFT_HOLD: if (cnt_expire) state_d = ST_RUN;
        ST_RUN: state_d = ST_RUN;
      endcase
    end
  end

  always_comb begin
    cnt_value = '0;
    unique case (state_d)
      // RULE2: stretch length
      ST_STRETCH: cnt_value = STRETCH_LOAD;
      // RULE3: lock time scales with divide factor
      ST_PLL_WAIT: cnt_value = rdf_two_q ? PLL_LOAD_2 : PLL_LOAD_1;
      // RULE4: hard release after lock
      ST_HARD_HOLD: cnt_value = HARD_LOAD;
      // RULE5: soft release three cycles later
      ST_SOFT_HOLD: cnt_value = SOFT_LOAD;
      ST_POR, ST_RUN: cnt_value = '0;
    endcase
  end

  // RULE9: delays run on one down-counter
  delay_down_counter #(
    .WIDTH(COUNT_WIDTH)
  ) u_delay (
    .clk(clk),
    .srst(srst),
    .load(cnt_load),
    .load_value(cnt_value),
    .tick(cnt_tick),
    .expire(cnt_expire),
    .remaining(remaining)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_POR;
    end else begin
      state_q <= state_d;
    end
  end

  logic por_int_q, pll_reset_q, pll_locked_q, hard_act_q, soft_act_q;

  // RULE8: resets held during power-on
  always_ff @(posedge clk) begin
    if (srst) begin
      por_int_q <= 1'b1;
      pll_reset_q <= 1'b1;
      pll_locked_q <= 1'b0;
      hard_act_q <= 1'b1;
      soft_act_q <= 1'b1;
    end else begin
      por_int_q <= (state_d == ST_POR || state_d == ST_STRETCH);
      pll_reset_q <= (state_d == ST_POR || state_d == ST_STRETCH);
      pll_locked_q <= (state_d == ST_HARD_HOLD ||
                       state_d == ST_SOFT_HOLD || state_d == ST_RUN);
      hard_act_q <= !(state_d == ST_SOFT_HOLD || state_d == ST_RUN);
      soft_act_q <= (state_d != ST_RUN);
    end
  end

  assign internal_por_n = !por_int_q;
  assign system_pll_reset = pll_reset_q;
  assign system_pll_locked = pll_locked_q;
  // Open-drain pins only ever pull low; the board pull-up releases them.
  assign hard_reset_n_o = 1'b0;
  assign hard_reset_n_oe = hard_act_q;
  assign soft_reset_n_o = 1'b0;
  assign soft_reset_n_oe = soft_act_q;

  // Straps and the reset pin share synchroniser depth, so the sample
  // taken on the rising edge lines up with the pin release.
  logic [NS-1:0] strap_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      strap_q <= `STRAP_RESET;
    end else if (por_rise) begin
      // RULE7: capture straps at release
      strap_q <= strap_sync;
    end
  end

  assign cfg_config_mode = strap_q[`STRAP_CFG_MODE];
  assign cfg_config_slave = strap_q[`STRAP_CFG_SLAVE];
  assign cfg_slave_port_sync = strap_q[`STRAP_PORT_SYNC];
  assign cfg_slave_port_wide = strap_q[`STRAP_PORT_WIDE];
  assign cfg_device_position = strap_q[`STRAP_POSITION_LSB +: 4];
  assign cfg_boot_mode = strap_q[`STRAP_BOOT_LSB +: 3];
  assign cfg_watchdog_enable = strap_q[`STRAP_WATCHDOG];
  assign cfg_clock_mode = strap_q[`STRAP_CLKMODE_LSB +: 2];

  // APB slave: read data is prepared in the setup cycle, so every
  // access completes in its first access cycle.
  logic setup_phase, write_access;
  logic [31:0] status_word;
  logic [31:0] prdata_q;
  logic pslverr_q;

  assign setup_phase = psel && !penable;
  assign write_access = psel && penable && pwrite;

  always_comb begin
    status_word = '0;
    status_word[`STATUS_STATE_LSB +: 3] = state_q;
    status_word[`STATUS_PLL_BIT] = pll_locked_q;
    status_word[`STATUS_HARD_PIN_BIT] = hard_pin_sync;
    status_word[`STATUS_SOFT_PIN_BIT] = soft_pin_sync;
    status_word[`STATUS_POR_PIN_BIT] = por_sync;
    status_word[`STATUS_REMAIN_LSB +: COUNT_WIDTH] = remaining;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_phase) begin
      pslverr_q <= 1'b0;
      case (paddr)
        `SEQ_CTRL_OFFSET: prdata_q <= {31'h0000_0000, rdf_two_q};
        `SEQ_STATUS_OFFSET: prdata_q <= status_word;
        `SEQ_STRAPS_OFFSET: prdata_q <= {{(32 - NS){1'b0}}, strap_q};
        default: begin
          prdata_q <= 32'h0000_0000;
          pslverr_q <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdf_two_q <= `CTRL_RDF_RESET;
    end else if (write_access && paddr == `SEQ_CTRL_OFFSET) begin
      rdf_two_q <= pwdata[`CTRL_RDF_BIT];
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = pslverr_q;

  // Checking helpers: ticks seen in the current state, and the divide
  // factor in force when the current count was loaded.
  logic [COUNT_WIDTH-1:0] phase_ticks_q;
  logic lock_two_q;
  always_ff @(posedge clk) begin
    if (srst || cnt_load) begin
      phase_ticks_q <= '0;
      lock_two_q <= rdf_two_q;
    end else if (cnt_tick) begin
      phase_ticks_q <= phase_ticks_q + COUNT_WIDTH'(1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_stretch_len: assert property ( // RULE2
    (state_q == ST_STRETCH && state_d == ST_PLL_WAIT)
    |-> phase_ticks_q == STRETCH_LOAD - COUNT_WIDTH'(1))
    else $error("internal reset stretch length wrong");
  chk_pll_lock_len: assert property ( // RULE3
    (state_q == ST_PLL_WAIT && state_d == ST_HARD_HOLD)
    |-> phase_ticks_q == (lock_two_q ? PLL_LOAD_2 : PLL_LOAD_1)
        - COUNT_WIDTH'(1))
    else $error("PLL lock wait length wrong");

  chk_hard_release: assert property ( // RULE4
    (state_q == ST_HARD_HOLD && state_d == ST_SOFT_HOLD)
    |-> phase_ticks_q == HARD_LOAD - COUNT_WIDTH'(1)
        ##1 !hard_reset_n_oe && soft_reset_n_oe)
    else $error("hard reset release timing wrong");

  chk_soft_release: assert property ( // RULE5
    (state_q == ST_SOFT_HOLD && state_d == ST_RUN)
    |-> phase_ticks_q == SOFT_LOAD - COUNT_WIDTH'(1)
        ##1 !soft_reset_n_oe)
    else $error("soft reset release timing wrong");

  chk_hard_implies_soft: assert property ( // RULE8
    hard_reset_n_oe |-> soft_reset_n_oe)
    else $error("soft reset released while hard reset held");
  chk_por_holds_pll: assert property ( // RULE8
    !por_sync |=> system_pll_reset && !system_pll_locked
                  && hard_reset_n_oe && !internal_por_n)
    else $error("power-on reset did not hold PLL and resets");

  chk_strap_capture: assert property ( // RULE7
    por_rise |=> strap_q == $past(strap_sync))
    else $error("straps not captured at reset release");
  chk_restart_seq: assert property ( // RULE9
    (!por_sync && state_q == ST_RUN) |=> state_q == ST_POR
    ##1 (state_q == ST_STRETCH || state_q == ST_POR))
    else $error("sequence did not restart");

endmodule : power_on_reset_sequencer

// ==== tb/reset_supervisor.sv ====
`timescale 1ns/1ps
module reset_supervisor (
  output logic input_clock,
  output logic reference_clock,
  output logic power_on_reset_n,
  output logic [13:0] straps
);
  initial begin
    input_clock = 1'b0;
    reference_clock = 1'b0;
    power_on_reset_n = 1'b0;
    straps = 14'h0000;
  end
  // Odd offsets keep both board clocks clear of the system clock edges.
  initial #3 forever #10 input_clock = ~input_clock;
  initial #5 forever #12 reference_clock = ~reference_clock;
  task automatic hold_por(input logic [13:0] s, input int n);
    power_on_reset_n = 1'b0;
    straps = s;
    // The call may land mid-period, so one extra edge keeps n full periods.
    repeat (n + 1) @(posedge input_clock);
  endtask : hold_por
  task automatic release_por();
    @(negedge input_clock);
    power_on_reset_n = 1'b1;
    repeat (4) @(posedge input_clock);
    @(negedge input_clock);
    straps = ~straps;
  endtask : release_por
endmodule : reset_supervisor

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`include "por_seq_params.svh"
module tb;
  import por_seq_pkg::*;
  localparam int ST_N = 8;
  localparam int PL_N = 20;
  localparam int HD_N = 6;
  localparam int SF_N = 9;
  logic clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic in_clk, ref_clk, por_n, hard_pin, soft_pin, hard_o, soft_o;
  logic hard_oe, soft_oe, int_por_n, pll_rst, pll_lock, err;
  logic [13:0] straps, cfg;
  int fail_count, checks_done, in_cnt, ref_cnt;
  int t_rel, t_por, t_lock_in, t_lock_ref, t_hard, t_soft;
  // Open-drain pins with board pull-ups.
  assign hard_pin = hard_oe ? hard_o : 1'b1;
  assign soft_pin = soft_oe ? soft_o : 1'b1;
  reset_supervisor sup (.input_clock(in_clk), .reference_clock(ref_clk),
    .power_on_reset_n(por_n), .straps(straps));
  power_on_reset_sequencer #(.STRETCH_CYCLES(ST_N),
    .PLL_LOCK_CYCLES(PL_N), .HARD_RELEASE_CYCLES(HD_N),
    .SOFT_RELEASE_CYCLES(SF_N)) DUT (.clk(clk), .srst(srst),
    .input_clock(in_clk), .reference_clock(ref_clk),
    .power_on_reset_n(por_n), .hard_reset_n_i(hard_pin),
    .hard_reset_n_o(hard_o), .hard_reset_n_oe(hard_oe),
    .soft_reset_n_i(soft_pin), .soft_reset_n_o(soft_o),
    .soft_reset_n_oe(soft_oe), .config_mode_strap(straps[0]),
    .config_slave_strap(straps[1]), .slave_port_sync_strap(straps[2]),
    .slave_port_wide_strap(straps[3]),
    .device_position_code(straps[7:4]), .boot_mode_strap(straps[10:8]),
    .watchdog_enable_strap(straps[11]), .clock_mode_strap(straps[13:12]),
    .internal_por_n(int_por_n), .system_pll_reset(pll_rst),
    .system_pll_locked(pll_lock), .cfg_config_mode(cfg[0]),
    .cfg_config_slave(cfg[1]), .cfg_slave_port_sync(cfg[2]),
    .cfg_slave_port_wide(cfg[3]), .cfg_device_position(cfg[7:4]),
    .cfg_boot_mode(cfg[10:8]), .cfg_watchdog_enable(cfg[11]),
    .cfg_clock_mode(cfg[13:12]), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  initial clk = 1'b0;
  always #2 clk = ~clk;
  // Edge stamps are exact because no board edge meets a system edge.
  always @(posedge in_clk) in_cnt++;
  always @(posedge ref_clk) ref_cnt++;
  always @(posedge int_por_n) t_por = in_cnt;
  always @(posedge pll_lock) begin
    t_lock_in = in_cnt;
    t_lock_ref = ref_cnt;
  end
  always @(negedge hard_oe) t_hard = ref_cnt;
  always @(negedge soft_oe) t_soft = ref_cnt;
  task automatic close_out();
    $display("Checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_rng(input string nm, input int lo, input int hi,
      input int g);
    checks_done++;
    if (g < lo || g > hi) begin
      fail_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng
  function automatic logic sig(input int w);
    case (w)
      0: return int_por_n;
      1: return pll_lock;
      2: return hard_oe;
      default: return soft_oe;
    endcase
  endfunction : sig
  task automatic wait_for(input string nm, input int w, input logic v);
    int n;
    n = 0;
    while (sig(w) !== v && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen timeout", nm, v);
      close_out();
    end
  endtask : wait_for
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      $display("[FAIL] pready expected 1 seen timeout");
      close_out();
    end
  endtask : apb
  task automatic run_seq(input logic pll_ref_divide_factor, input int abort);
    logic [13:0] s;
    logic [6:0] lv;
    int lk;
    s = abort ? 14'h3fff : 14'($urandom);
    apb(1'b1, `SEQ_CTRL_OFFSET, {31'h0, pll_ref_divide_factor});
    for (int k = 0; k <= abort; k++) begin
      s = k ? ~s : s;
      sup.hold_por(s, 16 + $urandom_range(0, 8));
      lv = {int_por_n, pll_rst, pll_lock, hard_oe, soft_oe, hard_pin, soft_pin};
      chk("asserted", 7'b0101100, lv);
      sup.release_por();
      t_rel = in_cnt - 4;
      wait_for("internal por", 0, 1'b1);
      chk("pll reset", 32'h0, pll_rst);
      chk_rng("stretch", ST_N, ST_N + 1, t_por - t_rel);
      chk("cfg", s, cfg);
      apb(1'b0, `SEQ_STRAPS_OFFSET, 32'h0);
      chk("straps reg", {18'h0, s}, rd);
    end
    lk = PL_N * (int'(pll_ref_divide_factor) + 1);
    wait_for("lock", 1, 1'b1);
    chk_rng("lock", lk - 1, lk + 1, t_lock_in - t_por);
    wait_for("hard", 2, 1'b0);
    chk("soft held", 32'h1, soft_oe);
    chk_rng("hard", HD_N - 1, HD_N + 1, t_hard - t_lock_ref);
    wait_for("soft", 3, 1'b0);
    chk_rng("soft", SF_N - HD_N, SF_N - HD_N, t_soft - t_hard);
    apb(1'b0, `SEQ_STATUS_OFFSET, 32'h0);
    chk("status", {3'b111, 1'b1, ST_RUN}, rd[6:0]);
    $display("test sequence rdf %b abort %0d done", pll_ref_divide_factor, abort);
  endtask : run_seq
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fail_count = 0;
    checks_done = 0;
    in_cnt = 0;
    ref_cnt = 0;
    void'($urandom(32'h3147764c));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, `SEQ_CTRL_OFFSET, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, `SEQ_STRAPS_OFFSET, 32'h0);
    chk("straps reset", 32'h0, rd);
    apb(1'b1, `SEQ_STATUS_OFFSET, 32'hffffffff);
    chk("ro write err", 32'h0, err);
    apb(1'b1, 12'h00c, 32'hffffffff);
    chk("unmapped err", 32'h1, err);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped read", 32'h0, rd);
    chk("unmapped read err", 32'h1, err);
    apb(1'b1, `SEQ_CTRL_OFFSET, 32'hffffffff);
    apb(1'b0, `SEQ_CTRL_OFFSET, 32'h0);
    chk("ctrl bits", 32'h1, rd);
    $display("test registers done");
    run_seq(1'b0, 0);
    run_seq(1'b1, 1);
    for (int i = 0; i < 3; i++) begin
      run_seq(1'($urandom_range(0, 1)), 0);
    end
    close_out();
  end
endmodule : tb
